/* File: acs_sequencer.sv */
/*
 * Converter control sequencer: serial control word capture on the shift
 * clock, track/hold and input selector timing, internal and external clock
 * conversions, strobe and serial result output.
 * Assumes a latched comparator on each conversion clock and a host that
 * drives serial_in and chip_select_b from the shift clock.
 */
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_sequencer (
   // system clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // serial link
   input wire logic shift_clk,
   input wire logic chip_select_b,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   output logic conversion_strobe,
   output logic conversion_strobe_oe,
   // analog front end
   input wire logic comparator_high_int,
   input wire logic comparator_high_ext,
   output logic track_hold_track,
   output logic input_selector_open,
   output logic [7:0] input_selector_pos,
   output logic [7:0] input_selector_neg,
   output logic input_selector_com,
   output logic unipolar_select,
   output acs_pkg::acs_code_t dac_code_int,
   output acs_pkg::acs_code_t dac_code_ext,
   // status
   output logic power_down_full,
   output logic power_down_fast,
   output logic external_clock_mode
);

   // -------------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------------
   logic [1:0] rst_pipe_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) rst_pipe_q <= 2'h0;
      else rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end
   wire rst_sync_b = rst_pipe_q[1];
   wire frame_rst_b = rst_sync_b & ~chip_select_b;
   wire shift_clk_fall = ~shift_clk;

   // -------------------------------------------------------------------------
   // control word capture, rising shift clock
   // -------------------------------------------------------------------------
   logic [3:0] rcnt_q;
   logic [7:0] word_q;
   logic [4:0] fcnt_q;
   wire word_full = (rcnt_q == `ACS_WORD_BITS);
   wire rearm = word_full && (fcnt_q >= `ACS_EDGE_DONE);
   wire start_seen = ((rcnt_q == 4'h0) || rearm) && serial_in;
   wire shifting = (rcnt_q != 4'h0) && !word_full;
   wire [3:0] rcnt_d = start_seen ? 4'h1 : rearm ? 4'h0 : shifting ? rcnt_q + 4'h1 : rcnt_q;
   wire [7:0] word_d = start_seen ? 8'h01 : shifting ? {word_q[6:0], serial_in} : word_q;

   always_ff @(posedge shift_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         rcnt_q <= 4'h0;
         word_q <= 8'h00;
      end else begin
         rcnt_q <= rcnt_d;
         word_q <= word_d;
      end
   end

   // -------------------------------------------------------------------------
   // word fields and edge events, falling shift clock
   // -------------------------------------------------------------------------
   wire [4:0] fcnt_nxt = fcnt_q + 5'h01;
   wire [4:0] fcnt_d = (rcnt_q == 4'h1) ? 5'h01 :
                       (rcnt_q == 4'h0) ? 5'h00 :
                       (fcnt_q == `ACS_EDGE_MAX) ? fcnt_q : fcnt_nxt;
   wire ev_track = (rcnt_q >= 4'h5) && (fcnt_nxt == `ACS_EDGE_TRACK);
   wire ev_hold = word_full && (fcnt_nxt == `ACS_EDGE_HOLD);
   wire ev_strobe_off = word_full && (fcnt_nxt == `ACS_EDGE_STROBE_OFF);
   wire ev_release = word_full && (fcnt_nxt == `ACS_EDGE_DONE);
   // at edge five the word holds bits 7..3 in its low five places
   wire [3:0] sel_now = word_q[3:0];
   wire [1:0] mode_now = word_q[`ACS_MODE_MSB:`ACS_MODE_LSB];
   wire word_ext = (mode_now == `ACS_MODE_EXT_CLK);

   logic [3:0] sel_word_q;
   logic [2:0] cfg_word_q;
   logic mode_ext_q;
   logic tgl_track_q;
   logic tgl_hold_q;
   logic tgl_release_q;
   logic [2:0] done_sync_q;
   logic done_tgl_q;

   always_ff @(negedge shift_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sel_word_q <= 4'h0;
         cfg_word_q <= {1'b0, `ACS_MODE_INT_CLK};
         mode_ext_q <= 1'b0;
         tgl_track_q <= 1'b0;
         tgl_hold_q <= 1'b0;
         tgl_release_q <= 1'b0;
         done_sync_q <= 3'h0;
      end else begin
         if (ev_track) sel_word_q <= sel_now;
         if (ev_hold) cfg_word_q <= word_q[`ACS_BIT_UNI:`ACS_MODE_LSB];
         if (ev_hold) mode_ext_q <= word_ext;
         tgl_track_q <= tgl_track_q ^ ev_track;
         tgl_hold_q <= tgl_hold_q ^ ev_hold;
         tgl_release_q <= tgl_release_q ^ (ev_release && mode_ext_q);
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      end
   end

   // -------------------------------------------------------------------------
   // external conversion and serial output, falling shift clock
   // -------------------------------------------------------------------------
   logic ext_deciding;
   acs_sar u_sar_ext (
      .clk(shift_clk_fall),
      .rst_b(frame_rst_b),
      .start(ev_hold && word_ext),
      .abort(1'b0),
      .comparator_high(comparator_high_ext),
      .trial_code(dac_code_ext),
      .deciding(ext_deciding),
      .busy(),
      .done()
   );

   acs_pkg::acs_code_t result_q;
   acs_pkg::acs_code_t rd_shift_q;
   logic serial_out_q;
   logic serial_out_oe_q;
   logic ext_strobe_q;
   logic ext_strobe_oe_q;
   wire done_seen = done_sync_q[2] ^ done_sync_q[1];
   wire out_d = ext_deciding ? comparator_high_ext : done_seen ? result_q[13] : rd_shift_q[13];
   wire [13:0] rd_shift_d = done_seen ? {result_q[12:0], 1'b0} : {rd_shift_q[12:0], 1'b0};
   wire ext_strobe_d = (ev_hold && word_ext) ? 1'b1 : ev_strobe_off ? 1'b0 : ext_strobe_q;

   always_ff @(negedge shift_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         serial_out_q <= 1'b0;
         serial_out_oe_q <= 1'b0;
         ext_strobe_q <= 1'b0;
         ext_strobe_oe_q <= 1'b0;
         rd_shift_q <= `ACS_CODE_ZERO;
         fcnt_q <= 5'h00;
      end else begin
         serial_out_q <= out_d;
         serial_out_oe_q <= 1'b1;
         ext_strobe_q <= ext_strobe_d;
         ext_strobe_oe_q <= 1'b1;
         rd_shift_q <= rd_shift_d;
         fcnt_q <= fcnt_d;
      end
   end

   // -------------------------------------------------------------------------
   // crossings into the system clock
   // -------------------------------------------------------------------------
   wire [3:0] sync_src = {chip_select_b, tgl_release_q, tgl_hold_q, tgl_track_q};
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] sync3_q;
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_sync
         always_ff @(posedge clock or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               sync1_q[i] <= (i == 3);
               sync2_q[i] <= (i == 3);
               sync3_q[i] <= (i == 3);
            end else begin
               sync1_q[i] <= sync_src[i];
               sync2_q[i] <= sync1_q[i];
               sync3_q[i] <= sync2_q[i];
            end
         end
      end
   endgenerate
   wire sys_track = sync2_q[0] ^ sync3_q[0];
   wire sys_hold = sync2_q[1] ^ sync3_q[1];
   wire sys_release = sync2_q[2] ^ sync3_q[2];
   wire sys_cs_high = sync2_q[3];

   // -------------------------------------------------------------------------
   // track/hold, selector and internal conversion, system clock
   // -------------------------------------------------------------------------
   logic [7:0] dec_pos;
   logic [7:0] dec_neg;
   logic dec_com;
   acs_chan_decode u_decode (
      .select(sel_word_q[3:1]),
      .single_ended_select(sel_word_q[0]),
      .pos_onehot(dec_pos),
      .neg_onehot(dec_neg),
      .com_negative(dec_com)
   );

   acs_pkg::acs_state_t state_q;
   acs_pkg::acs_state_t state_d;
   logic int_done;
   wire cfg_ext = (cfg_word_q[1:0] == `ACS_MODE_EXT_CLK);
   wire int_abort = sys_cs_high && (state_q == acs_pkg::ACS_ST_CONV);
   wire int_start = sys_hold && (state_q == acs_pkg::ACS_ST_TRACK) && !cfg_ext;

   acs_sar u_sar_int (
      .clk(clock),
      .rst_b(rst_sync_b),
      .start(int_start),
      .abort(int_abort),
      .comparator_high(comparator_high_int),
      .trial_code(dac_code_int),
      .deciding(),
      .busy(),
      .done(int_done)
   );

   logic track_d;
   logic connect;
   logic finish;
   always_comb begin
      state_d = state_q;
      track_d = track_hold_track;
      connect = 1'b0;
      finish = 1'b0;
      case (state_q)
         acs_pkg::ACS_ST_IDLE, acs_pkg::ACS_ST_TRACK: begin
            if (sys_hold && state_q == acs_pkg::ACS_ST_TRACK) begin
               track_d = 1'b0;
               state_d = cfg_ext ? acs_pkg::ACS_ST_HOLD : acs_pkg::ACS_ST_CONV;
            end else if (sys_track) begin
               track_d = 1'b1;
               connect = 1'b1;
               state_d = acs_pkg::ACS_ST_TRACK;
            end
         end
         acs_pkg::ACS_ST_CONV: begin
            if (int_abort || int_done) begin
               track_d = 1'b1;
               connect = 1'b1;
               finish = int_done;
               state_d = acs_pkg::ACS_ST_IDLE;
            end
         end
         acs_pkg::ACS_ST_HOLD: begin
            if (sys_release) begin
               track_d = 1'b1;
               connect = 1'b1;
               finish = 1'b1;
               state_d = acs_pkg::ACS_ST_IDLE;
            end
         end
         default: begin
            state_d = acs_pkg::ACS_ST_IDLE;
         end
      endcase
   end

   wire hold_now = sys_hold && (state_q == acs_pkg::ACS_ST_TRACK);
   logic conversion_strobe_int_q;
   wire strobe_d = int_start ? 1'b0 : (int_done || int_abort) ? 1'b1 : conversion_strobe_int_q;

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_q <= acs_pkg::ACS_ST_IDLE;
         track_hold_track <= 1'b1;
         input_selector_open <= 1'b1;
         input_selector_pos <= 8'h00;
         input_selector_neg <= 8'h00;
         input_selector_com <= 1'b0;
         unipolar_select <= 1'b0;
         power_down_full <= 1'b0;
         power_down_fast <= 1'b0;
         conversion_strobe_int_q <= 1'b1;
         result_q <= `ACS_CODE_ZERO;
         done_tgl_q <= 1'b0;
      end else begin
         state_q <= state_d;
         track_hold_track <= track_d;
         input_selector_open <= hold_now ? 1'b1 : connect ? 1'b0 : input_selector_open;
         if (connect) input_selector_pos <= dec_pos;
         if (connect) input_selector_neg <= dec_neg;
         if (connect) input_selector_com <= dec_com;
         if (hold_now) unipolar_select <= cfg_word_q[2];
         if (finish) power_down_full <= (cfg_word_q[1:0] == `ACS_MODE_FULL_PD);
         else if (sys_track) power_down_full <= 1'b0;
         if (finish) power_down_fast <= (cfg_word_q[1:0] == `ACS_MODE_FAST_PD);
         else if (sys_track) power_down_fast <= 1'b0;
         conversion_strobe_int_q <= strobe_d;
         result_q <= int_abort ? `ACS_CODE_ZERO : int_done ? dac_code_int : result_q;
         done_tgl_q <= done_tgl_q ^ int_done;
      end
   end

   // -------------------------------------------------------------------------
   // pin outputs
   // -------------------------------------------------------------------------
   // strobe pin is shared by both clock modes; the mode flop picks the source
   assign conversion_strobe = mode_ext_q ? ext_strobe_q : conversion_strobe_int_q;
   assign conversion_strobe_oe = mode_ext_q ? ext_strobe_oe_q : 1'b1;
   assign serial_out = serial_out_q;
   assign serial_out_oe = serial_out_oe_q;
   assign external_clock_mode = mode_ext_q;

endmodule // acs_sequencer

/* File: acs_defines.svh */
/*
 * Constants of the converter control sequencer: control word fields, mode codes,
 * shift-clock edge numbers and conversion lengths.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ----------------------------------------------------------------------------
// control word layout
// ----------------------------------------------------------------------------
`define ACS_WORD_BITS 4'h8
`define ACS_BIT_START 7
`define ACS_SEL_MSB 6
`define ACS_SEL_LSB 4
`define ACS_BIT_SGL 3
`define ACS_BIT_UNI 2
`define ACS_MODE_MSB 1
`define ACS_MODE_LSB 0

// ----------------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------------
`define ACS_MODE_FULL_PD 2'h0
`define ACS_MODE_FAST_PD 2'h1
`define ACS_MODE_INT_CLK 2'h2
`define ACS_MODE_EXT_CLK 2'h3

// ----------------------------------------------------------------------------
// falling shift-clock edge numbers within a word
// ----------------------------------------------------------------------------
`define ACS_EDGE_TRACK 5'h05
`define ACS_EDGE_HOLD 5'h08
`define ACS_EDGE_STROBE_OFF 5'h0A
`define ACS_EDGE_DONE 5'h12
`define ACS_EDGE_MAX 5'h1F

// ----------------------------------------------------------------------------
// conversion
// ----------------------------------------------------------------------------
`define ACS_RES_BITS 14
`define ACS_SAR_CYCLES 4'hF
`define ACS_CODE_MSB_TRIAL 14'h2000
`define ACS_CODE_ZERO 14'h0000

`endif

/* File: acs_pkg.sv */
/*
 * Types of the converter control sequencer.
 * Assumes acs_defines.svh is compiled alongside.
 */
package acs_pkg;

   // conversion state, one-hot
   typedef enum logic [3:0] {
      ACS_ST_IDLE = 4'h1,
      ACS_ST_TRACK = 4'h2,
      ACS_ST_CONV = 4'h4,
      ACS_ST_HOLD = 4'h8
   } acs_state_t;

   typedef logic [13:0] acs_code_t;

endpackage

/* File: acs_sar.sv */
/*
 * Successive-approximation engine: 15 conversion clocks, one settle clock then
 * one decision per bit, MSB first.
 * Assumes comparator_high is a latched comparator decision on clk.
 */
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_sar (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic comparator_high,
   // state
   output acs_pkg::acs_code_t trial_code,
   output logic deciding,
   output logic busy,
   output logic done
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   acs_pkg::acs_code_t code_q;
   acs_pkg::acs_code_t code_d;
   logic busy_q;
   logic busy_d;
   logic done_q;
   wire [13:0] msb_trial = `ACS_CODE_MSB_TRIAL;

   // cnt 15 settles, cnt 14..1 decide bits 13..0
   assign deciding = busy_q && (cnt_q <= 4'(`ACS_RES_BITS));
   assign cnt_d = abort ? 4'h0 : start ? `ACS_SAR_CYCLES : busy_q ? cnt_q - 4'h1 : cnt_q;
   assign busy_d = !abort && (start || (busy_q && cnt_q != 4'h1));

   genvar i;
   generate
      for (i = 0; i < `ACS_RES_BITS; i++) begin : g_bit
         wire decide_here = deciding && (cnt_q == 4'(i + 1));
         wire trial_here = deciding && (cnt_q == 4'(i + 2));
         assign code_d[i] = abort ? 1'b0 :
                            start ? msb_trial[i] :
                            decide_here ? comparator_high :
                            trial_here ? 1'b1 : code_q[i];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 4'h0;
         code_q <= `ACS_CODE_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         code_q <= code_d;
         busy_q <= busy_d;
         done_q <= !abort && busy_q && cnt_q == 4'h1;
      end
   end

   assign trial_code = code_q;
   assign busy = busy_q;
   assign done = done_q;

endmodule // acs_sar

/* File: acs_chan_decode.sv */
/*
 * Channel select decoder for the input selector: positive and negative
 * one-hot channel enables and the common-input connection.
 * Assumes pure combinational use.
 */
`timescale 1ns/1ps

module acs_chan_decode (
   // control word fields
   input wire logic [2:0] select,
   input wire logic single_ended_select,
   // selector enables
   output logic [7:0] pos_onehot,
   output logic [7:0] neg_onehot,
   output logic com_negative
);

   // codes 000,100,001,101,... walk the channels; pairs share the same order
   wire [2:0] pos_ch = {select[1], select[0], select[2]};
   wire [2:0] neg_ch = {select[1], select[0], ~select[2]};

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_ch
         assign pos_onehot[i] = (pos_ch == 3'(i));
         assign neg_onehot[i] = !single_ended_select && (neg_ch == 3'(i));
      end
   endgenerate

   assign com_negative = single_ended_select;

endmodule // acs_chan_decode

/* File: acs_sequencer_sva.sv */
/*
 * Checker of the converter control sequencer, bound to its top ports.
 * Assumes the system clock domain; rst_b is the raw active-low reset.
 */
`timescale 1ns/1ps

module acs_sequencer_sva (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // link
   input wire logic chip_select_b,
   input wire logic serial_out_oe,
   input wire logic conversion_strobe,
   input wire logic conversion_strobe_oe,
   // front end and status
   input wire logic track_hold_track,
   input wire logic input_selector_open,
   input wire logic [7:0] input_selector_pos,
   input wire logic [7:0] input_selector_neg,
   input wire logic input_selector_com,
   input wire logic power_down_full,
   input wire logic power_down_fast,
   input wire logic external_clock_mode
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ---------------------------------------------------------------
   // internal strobe low-time counter
   // ---------------------------------------------------------------
   logic [4:0] low_cnt_q;
   logic [4:0] low_cnt_d;
   logic int_low;
   assign int_low = !conversion_strobe && !external_clock_mode;
   assign low_cnt_d = !int_low ? 5'h00 : (low_cnt_q == 5'h1F ? low_cnt_q : low_cnt_q + 5'h01);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_q <= 5'h00;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence int_done;
      $rose(conversion_strobe) && !external_clock_mode && !$past(external_clock_mode) && !chip_select_b;
   endsequence

   a_conv_length: assert property (int_done |-> low_cnt_q >= 5'h0F && low_cnt_q <= 5'h12)
      else $error("internal conversion length wrong");
   a_track_restored: assert property (int_done |-> track_hold_track && !input_selector_open)
      else $error("track or selector not restored at completion");
   a_hold_kept: assert property ($fell(conversion_strobe) && !external_clock_mode
      |-> ##1 (!track_hold_track || conversion_strobe) [*8])
      else $error("track resumed during conversion");
   a_hold_opens: assert property (!track_hold_track |-> input_selector_open)
      else $error("selector closed while holding");
   a_pos_onehot: assert property (!input_selector_open |-> $onehot(input_selector_pos))
      else $error("positive selector not one-hot");
   a_single_com: assert property (input_selector_com |-> input_selector_neg == 8'h00)
      else $error("negative channel set in single-ended mode");
   a_diff_pair: assert property (!input_selector_com && !input_selector_open
      |-> $onehot(input_selector_neg) && (input_selector_neg & input_selector_pos) == 8'h00)
      else $error("differential pair malformed");
   a_dout_oe_off: assert property (chip_select_b |-> !serial_out_oe)
      else $error("serial output driven while deselected");
   a_ext_oe_off: assert property (external_clock_mode && chip_select_b |-> !conversion_strobe_oe)
      else $error("external strobe driven while deselected");
   a_int_oe_on: assert property (!external_clock_mode |-> conversion_strobe_oe)
      else $error("internal strobe not driven");
   a_pd_exclusive: assert property (!(power_down_full && power_down_fast))
      else $error("both power-down flags set");

   c_int_done: cover property (int_done);
   c_ext_mode: cover property ($rose(external_clock_mode));
   c_pd_fast: cover property ($rose(power_down_fast));
   c_abort: cover property (chip_select_b && !conversion_strobe);
endmodule // acs_sequencer_sva

/* File: acs_host_model.sv */
/*
 * Host model: serial master that shifts control words and samples the
 * result and strobe on rising shift-clock edges.
 * Assumes calls start off the system clock edges; 32 ns shift period.
 */
`timescale 1ns/1ps

module acs_host_model (
   // link to the converter
   output logic shift_clk,
   output logic chip_select_b,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic conversion_strobe
);
   logic [31:0] dout_q;
   logic [31:0] strb_q;

   initial begin
      shift_clk = 1'b0;
      chip_select_b = 1'b1;
      serial_in = 1'b0;
   end

   // clock runs only inside the frame, msb first
   task automatic frame(input logic [31:0] bits, input int n);
      #7;
      chip_select_b = 1'b0;
      for (int k = 0; k < n; k++) begin
         serial_in = bits[n-1-k];
         #16;
         shift_clk = 1'b1;
         dout_q[k] = serial_out;
         strb_q[k] = conversion_strobe;
         #16;
         shift_clk = 1'b0;
      end
      serial_in = ~serial_in;
   endtask

   task automatic release_cs();
      #7;
      chip_select_b = 1'b1;
      #16;
   endtask
endmodule // acs_host_model

/* File: tb_adc_control_byte_sequencer.sv */
/*
 * Testbench of the converter control sequencer.
 * Assumes acs_defines.svh, acs_pkg and the design files compiled first.
 */
`timescale 1ns/1ps

module tb_adc_control_byte_sequencer;
   logic clock, rst_b, comparator_high_int, comparator_high_ext;
   logic shift_clk, chip_select_b, serial_in, serial_out, serial_out_oe;
   logic conversion_strobe, conversion_strobe_oe, track_hold_track, input_selector_open;
   logic input_selector_com, unipolar_select, power_down_full, power_down_fast, external_clock_mode;
   logic [7:0] input_selector_pos, input_selector_neg;
   logic [13:0] dac_code_int;
   int n_errors, compares;
   int cycles = 0;

   acs_sequencer dut (.clock(clock), .rst_b(rst_b), .shift_clk(shift_clk), .chip_select_b(chip_select_b),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .conversion_strobe(conversion_strobe), .conversion_strobe_oe(conversion_strobe_oe),
      .comparator_high_int(comparator_high_int), .comparator_high_ext(comparator_high_ext),
      .track_hold_track(track_hold_track), .input_selector_open(input_selector_open),
      .input_selector_pos(input_selector_pos), .input_selector_neg(input_selector_neg),
      .input_selector_com(input_selector_com), .unipolar_select(unipolar_select), .dac_code_int(dac_code_int),
      .dac_code_ext(), .power_down_full(power_down_full), .power_down_fast(power_down_fast),
      .external_clock_mode(external_clock_mode));

   acs_host_model host (.shift_clk(shift_clk), .chip_select_b(chip_select_b), .serial_in(serial_in),
      .serial_out(serial_out), .conversion_strobe(conversion_strobe));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         give_verdict();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic send(input logic [31:0] bits, input int n);
      @(negedge clock);
      host.frame(bits, n);
   endtask

   task automatic drop();
      @(negedge clock);
      host.release_cs();
   endtask

   task automatic wait_strobe(input logic level);
      int i;
      i = 0;
      while (conversion_strobe !== level && i < 40) begin
         @(negedge clock);
         i++;
      end
      check(conversion_strobe === level, "strobe level not reached");
   endtask

   task automatic give_verdict();
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      check(conversion_strobe === 1'b1 && external_clock_mode === 1'b0, "reset mode");
      check(track_hold_track === 1'b1 && input_selector_open === 1'b1 && serial_out_oe === 1'b0, "reset front end");
      send(32'h0, 24);
      check(host.dout_q[23:0] === 24'h000000, "output before first conversion");
      check(host.strb_q[23:0] === 24'hFFFFFF, "strobe idle high");
      drop();
   endtask

   task automatic test_channels();
      logic [2:0] sel;
      logic [1:0] md;
      logic [7:0] ep;
      logic [7:0] en;
      for (int i = 0; i < 16; i++) begin
         sel = i[2:0];
         md = 2'(i % 3);
         ep = i[3] ? 8'h01 << {sel[1], sel[0], sel[2]} : 8'h01 << {sel[1:0], sel[2]};
         en = i[3] ? 8'h00 : 8'h01 << {sel[1:0], ~sel[2]};
         @(negedge clock);
         comparator_high_int = i[0];
         send({24'h000000, 1'b1, sel, i[3], i[1], md}, 8);
         wait_strobe(1'b0);
         wait_strobe(1'b1);
         repeat (3) @(negedge clock);
         check(track_hold_track === 1'b1 && input_selector_open === 1'b0, "not tracking after conversion");
         check(input_selector_pos === ep && input_selector_neg === en, "selector channels");
         check(input_selector_com === i[3], "common input");
         check(unipolar_select === i[1], "coding");
         check(power_down_full === (md == 2'h0) && power_down_fast === (md == 2'h1), "mode flags");
         send(32'h0, 24);
         check($countones(host.dout_q[23:0]) == (i[0] ? 14 : 0) && ^host.dout_q[23:0] !== 1'bx, "result");
         check(dac_code_int === (i[0] ? 14'h3FFF : 14'h0000), "converted code");
         drop();
      end
   endtask

   task automatic test_abort();
      @(negedge clock);
      comparator_high_int = 1'b1;
      send(32'h0000008E, 8);
      wait_strobe(1'b0);
      drop();
      wait_strobe(1'b1);
      repeat (3) @(negedge clock);
      check(track_hold_track === 1'b1 && dac_code_int === 14'h0000, "not tracking after abort");
      send(32'h0, 24);
      check(host.dout_q[23:0] === 24'h000000, "result not cleared");
      drop();
   endtask

   task automatic test_external();
      for (int r = 0; r < 2; r++) begin
         send(32'h00FF0000, 26);
         drop();
      end
      check(host.strb_q[12:10] === 3'b011, "strobe pulse");
      check(host.dout_q[25:12] === 14'h3FFF && host.dout_q[11:0] === 12'h000, "result bits");
      check(external_clock_mode === 1'b1 && unipolar_select === 1'b1, "all-ones word mode");
      check(input_selector_pos === 8'h80 && input_selector_com === 1'b1, "all-ones channel");
      check(track_hold_track === 1'b1, "not tracking after external conversion");
      check(conversion_strobe_oe === 1'b0 && serial_out_oe === 1'b0, "outputs not released");
   endtask

   initial begin
      rst_b = 1'b0;
      comparator_high_int = 1'b0;
      comparator_high_ext = 1'b1;
      n_errors = 0;
      compares = 0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      test_reset();
      test_channels();
      test_abort();
      test_external();
      give_verdict();
   end
endmodule // tb_adc_control_byte_sequencer

bind acs_sequencer acs_sequencer_sva chk (.clock(clock), .rst_b(rst_b), .chip_select_b(chip_select_b),
   .serial_out_oe(serial_out_oe), .conversion_strobe(conversion_strobe),
   .conversion_strobe_oe(conversion_strobe_oe), .track_hold_track(track_hold_track),
   .input_selector_open(input_selector_open), .input_selector_pos(input_selector_pos),
   .input_selector_neg(input_selector_neg), .input_selector_com(input_selector_com),
   .power_down_full(power_down_full), .power_down_fast(power_down_fast),
   .external_clock_mode(external_clock_mode));
